/* ptmr_pkg.sv */
// Package of constants and types for the prescaled one-shot waveform timer
package ptmr_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned AW    = 4;  // Register address width
    localparam int unsigned DW    = 8;  // Register data width
    localparam int unsigned DIV_W = 3;  // Count source divider width

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [AW-1:0] A_CTRL = 4'h0;  // Timer control
    localparam logic [AW-1:0] A_OSC  = 4'h1;  // One-shot control
    localparam logic [AW-1:0] A_IOC  = 4'h2;  // Timer I/O control
    localparam logic [AW-1:0] A_MODE = 4'h3;  // Timer mode
    localparam logic [AW-1:0] A_PRE  = 4'h4;  // Prescaler
    localparam logic [AW-1:0] A_SEC  = 4'h5;  // Secondary reload
    localparam logic [AW-1:0] A_PRI  = 4'h6;  // Primary reload
    localparam logic [AW-1:0] A_STAT = 4'h7;  // Interrupt status
    localparam logic [AW-1:0] A_MASK = 4'h8;  // Interrupt mask
    localparam logic [AW-1:0] A_PORT = 4'h9;  // Port data of the wave pin

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned B_START  = 0;  // count_start
    localparam int unsigned B_STATUS = 1;  // count_status
    localparam int unsigned B_FSTOP  = 2;  // forced_stop
    localparam int unsigned B_OSST   = 0;  // one_shot_start
    localparam int unsigned B_OSSP   = 1;  // one_shot_stop
    localparam int unsigned B_OSSTF  = 2;  // one_shot_status
    localparam int unsigned B_LEVEL  = 0;  // Idle output level
    localparam int unsigned B_TRGEN  = 1;  // External trigger enable
    localparam int unsigned B_DIR    = 2;  // Port direction, 1 = output
    localparam int unsigned B_MODE   = 0;  // Mode field, two bits
    localparam int unsigned B_SRC    = 4;  // Count source field, two bits
    localparam int unsigned B_UF     = 0;  // Counter underflow event
    localparam int unsigned B_OSEND  = 1;  // One-shot end event

    // ------------------------------------------------------------
    // Reset values and divider settings
    // ------------------------------------------------------------
    localparam logic [DW-1:0]    PRE_RST = 8'hff;  // Prescaler reset value
    localparam logic [DW-1:0]    PRI_RST = 8'hff;  // Primary reset value
    localparam logic [DW-1:0]    SEC_RST = 8'hff;  // Secondary reset value
    localparam logic [DIV_W-1:0] DIV8    = 3'h7;   // Terminal count of /8

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        M_TIMER = 2'h0,  // Plain timer
        M_WAVE  = 2'h1,  // Waveform generation
        M_OS    = 2'h3,  // One-shot
        M_WAIT  = 2'h2   // Wait one-shot
    } ptmr_mode_t;

    typedef struct packed {
        logic [AW-1:0] addr;   // Register address
        logic [DW-1:0] wdata;  // Write data
        logic          wr;     // Write strobe
        logic          rd;     // Read strobe
    } ptmr_bus_t;

endpackage

/* ptmr_top.sv */
// Prescaled 8-bit down-counting timer with waveform and one-shot modes
// What this block does
// - Timer stays stopped after reset
// - Prescaler and counter read as separate bytes
// - One-shot stop halts counter, then reloads it
// - Status rises 1-2 source cycles after start
// - Status falls 1-2 cycles later; halt then
// - Forced stop halts immediately
// - One-shot status follows requests after 1-2 cycles
// - Crossing one-shot requests settle to the last one; stop wins a tie
// - Input-direction port read returns waveform level
// - Forced stop in waveform restores prescaler and primary reset values
module ptmr_top
    import ptmr_pkg::*;
(
    // Clock and reset
    input  wire logic                I_CLK,
    input  wire logic                I_NRST,
    // Register port
    input  wire ptmr_pkg::ptmr_bus_t I_BUS,
    output logic [ptmr_pkg::DW-1:0]  O_RDATA,
    // Pins
    input  wire logic                I_TRIG,
    output logic                     O_WAVE,
    output logic                     O_WAVE_OE,
    // Interrupt
    output logic                     O_IRQ
);
    import ptmr_pkg::*;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // Write hit on one register offset
    function automatic logic wr_hit(input ptmr_bus_t b, input logic [AW-1:0] a);
        return b.wr && (b.addr == a);
    endfunction

    // Read hit on one register offset
    function automatic logic rd_hit(input ptmr_bus_t b, input logic [AW-1:0] a);
        return b.rd && (b.addr == a);
    endfunction

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic             count_start;      // Software start request
    logic             start_sync;       // First stage toward count_status
    logic             count_status;     // Counting in progress
    logic             os_pend;          // One-shot request waiting for a tick
    logic             os_pend_val;      // Value of that request
    logic             os_stage;         // Request staged, one tick from effect
    logic             os_stage_val;     // Staged value
    logic             one_shot_status;  // One-shot in progress
    ptmr_mode_t       mode;             // Operating mode
    logic [1:0]       src_sel;          // Count source select
    logic [DIV_W-1:0] div;              // Free divider
    logic [DW-1:0]    pre_reload;       // Prescaler reload
    logic [DW-1:0]    pri_reload;       // Primary reload
    logic [DW-1:0]    sec_reload;       // Secondary reload
    logic [DW-1:0]    pre_cnt;          // Prescaler count
    logic [DW-1:0]    cnt;              // Timer count
    logic             phase;            // 0 primary period, 1 secondary
    logic             out_level;        // Idle output level
    logic             trig_en;          // External trigger enable
    logic             port_dir;         // Pin direction, 1 = driven
    logic             port_data;        // Port data latch
    logic [2:0]       trig_ff;          // Trigger synchroniser
    logic             trig_lvl;         // Filtered trigger level
    logic             trig_evt;         // Accepted rising trigger
    logic [1:0]       irq_stat;         // Sticky events
    logic [1:0]       irq_mask;         // Event enables
    logic [DW-1:0]    rdata;            // Read data
    logic             wave;             // Waveform output
    logic             irq;              // Interrupt output

    // ------------------------------------------------------------
    // Combinational helpers
    // ------------------------------------------------------------
    logic tick;         // One count source cycle
    logic fstop;        // Forced stop write
    logic one_shot_m;   // Either one-shot mode
    logic run;          // Counting is active
    logic uf_evt;       // Timer counter underflow
    logic os_done;      // One-shot finished
    logic next_wave;    // Next waveform level
    logic [DW-1:0] rd_mux;  // Read selection

    // Count source: /1, /2 or /8 of the clock as an enable
    always_comb begin
        unique case (src_sel)
            2'h0:    tick = 1'b1;
            2'h1:    tick = div[0];
            default: tick = (div == DIV8);
        endcase
    end

    assign fstop      = wr_hit(I_BUS, A_CTRL) && I_BUS.wdata[B_FSTOP];
    assign one_shot_m = (mode == M_OS) || (mode == M_WAIT);
    assign run        = count_status && (!one_shot_m || one_shot_status);
    assign uf_evt     = run && tick && (pre_cnt == 8'h00) && (cnt == 8'h00);
    assign os_done    = uf_evt && ((mode == M_OS) || ((mode == M_WAIT) && phase));

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    // Free-running so the source phase is independent of start
    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            div <= '0;
        end else begin
            div <= div + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Start and stop
    // ------------------------------------------------------------
    // Software start bit, cleared by a forced stop
    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            count_start <= 1'b0;
        end else if (wr_hit(I_BUS, A_CTRL)) begin
            count_start <= I_BUS.wdata[B_START] && !I_BUS.wdata[B_FSTOP];
        end
    end

    // Two ticks of staging give the 1 to 2 source cycle lag both ways
    always_ff @(posedge I_CLK) begin
        if (!I_NRST || fstop) begin
            start_sync   <= 1'b0;
            count_status <= 1'b0;
        end else if (tick) begin
            start_sync   <= count_start;
            count_status <= start_sync;
        end
    end

    // ------------------------------------------------------------
    // External trigger
    // ------------------------------------------------------------
    // Three flops; a level is taken once stages two and three agree
    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            trig_ff  <= 3'h0;
            trig_lvl <= 1'b0;
            trig_evt <= 1'b0;
        end else begin
            trig_ff  <= {trig_ff[1:0], I_TRIG};
            trig_evt <= 1'b0;
            if (trig_ff[1] == trig_ff[2]) begin
                trig_lvl <= trig_ff[2];
                trig_evt <= trig_ff[2] && !trig_lvl;
            end
        end
    end

    // ------------------------------------------------------------
    // One-shot control
    // ------------------------------------------------------------
    // Later request overwrites a pending one, so crossing
    // start and stop settle to whichever arrived last
    always_ff @(posedge I_CLK) begin
        if (!I_NRST || fstop) begin
            os_pend         <= 1'b0;
            os_pend_val     <= 1'b0;
            os_stage        <= 1'b0;
            os_stage_val    <= 1'b0;
            one_shot_status <= 1'b0;
        end else begin
            if (wr_hit(I_BUS, A_OSC) && I_BUS.wdata[B_OSSP]) begin
                os_pend     <= 1'b1;
                os_pend_val <= 1'b0;
            end else if ((wr_hit(I_BUS, A_OSC) && I_BUS.wdata[B_OSST]) ||
                         (trig_evt && trig_en && one_shot_m)) begin
                os_pend     <= 1'b1;
                os_pend_val <= 1'b1;
            end else if (tick) begin
                os_pend     <= 1'b0;
            end
            if (tick) begin
                os_stage     <= os_pend;
                os_stage_val <= os_pend_val;
            end
            // Completion by hardware and a staged request take effect here
            if (tick && os_stage) begin
                one_shot_status <= os_stage_val;
            end else if (os_done) begin
                one_shot_status <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    // Mode, source and pin controls
    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            mode      <= M_TIMER;
            src_sel   <= 2'h0;
            out_level <= 1'b0;
            trig_en   <= 1'b0;
            port_dir  <= 1'b0;
            port_data <= 1'b0;
        end else begin
            if (wr_hit(I_BUS, A_MODE)) begin
                mode    <= ptmr_mode_t'(I_BUS.wdata[B_MODE +: 2]);
                src_sel <= I_BUS.wdata[B_SRC +: 2];
            end
            if (wr_hit(I_BUS, A_IOC)) begin
                out_level <= I_BUS.wdata[B_LEVEL];
                trig_en   <= I_BUS.wdata[B_TRGEN];
                port_dir  <= I_BUS.wdata[B_DIR];
            end
            if (wr_hit(I_BUS, A_PORT)) begin
                port_data <= I_BUS.wdata[0];
            end
        end
    end

    // Reload values; a forced stop in waveform mode restores them
    always_ff @(posedge I_CLK) begin
        if (!I_NRST || (fstop && (mode == M_WAVE))) begin
            pre_reload <= PRE_RST;
            pri_reload <= PRI_RST;
        end else begin
            if (wr_hit(I_BUS, A_PRE)) begin
                pre_reload <= I_BUS.wdata;
            end
            if (wr_hit(I_BUS, A_PRI)) begin
                pri_reload <= I_BUS.wdata;
            end
        end
    end

    // Secondary reload, used by waveform and wait one-shot
    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            sec_reload <= SEC_RST;
        end else if (wr_hit(I_BUS, A_SEC)) begin
            sec_reload <= I_BUS.wdata;
        end
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // Writes while counting only change the reloads; the counter
    // takes them at the next underflow
    always_ff @(posedge I_CLK) begin
        if (!I_NRST || (fstop && (mode == M_WAVE))) begin
            pre_cnt <= PRE_RST;
            cnt     <= PRI_RST;
            phase   <= 1'b0;
        end else if (one_shot_m && !run) begin
            pre_cnt <= pre_reload;
            cnt     <= pri_reload;
            phase   <= 1'b0;
        end else if (!count_status) begin
            if (wr_hit(I_BUS, A_PRE)) begin
                pre_cnt <= I_BUS.wdata;
            end
            if (wr_hit(I_BUS, A_PRI)) begin
                cnt   <= I_BUS.wdata;
                phase <= 1'b0;
            end
        end else if (run && tick) begin
            if (pre_cnt != 8'h00) begin
                pre_cnt <= pre_cnt - 8'h01;
            end else begin
                pre_cnt <= pre_reload;
                if (cnt != 8'h00) begin
                    cnt <= cnt - 8'h01;
                end else begin
                    // Underflow: pick the next period by mode
                    unique case (mode)
                        M_TIMER: begin
                            cnt <= pri_reload;
                        end
                        M_WAVE: begin
                            cnt   <= phase ? pri_reload : sec_reload;
                            phase <= !phase;
                        end
                        M_OS: begin
                            cnt <= pri_reload;
                        end
                        M_WAIT: begin
                            cnt   <= phase ? pri_reload : sec_reload;
                            phase <= !phase;
                        end
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Waveform output
    // ------------------------------------------------------------
    // Active level is the inverse of the idle level
    always_comb begin
        unique case (mode)
            M_TIMER: next_wave = out_level;
            M_WAVE:  next_wave = out_level ^ (count_status && phase);
            M_OS:    next_wave = out_level ^ run;
            M_WAIT:  next_wave = out_level ^ (run && phase);
        endcase
    end

    // Registered pin level
    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            wave <= 1'b0;
        end else begin
            wave <= next_wave;
        end
    end

    // ------------------------------------------------------------
    // Interrupt
    // ------------------------------------------------------------
    // Reading the status clears it, but a same-cycle event survives
    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            irq_stat <= 2'h0;
            irq_mask <= 2'h0;
            irq      <= 1'b0;
        end else begin
            irq_stat[B_UF]    <= uf_evt ||
                                 (irq_stat[B_UF] && !rd_hit(I_BUS, A_STAT));
            irq_stat[B_OSEND] <= os_done ||
                                 (irq_stat[B_OSEND] && !rd_hit(I_BUS, A_STAT));
            if (wr_hit(I_BUS, A_MASK)) begin
                irq_mask <= I_BUS.wdata[1:0];
            end
            irq <= |(irq_stat & irq_mask);
        end
    end

    // ------------------------------------------------------------
    // Read back
    // ------------------------------------------------------------
    // Each byte is read alone, so a wide read may see the count move
    always_comb begin
        unique case (I_BUS.addr)
            A_CTRL:  rd_mux = {6'h00, count_status, count_start};
            A_OSC:   rd_mux = {5'h00, one_shot_status, 2'h0};
            A_IOC:   rd_mux = {5'h00, port_dir, trig_en, out_level};
            A_MODE:  rd_mux = {2'h0, src_sel, 2'h0, mode};
            A_PRE:   rd_mux = pre_cnt;
            A_SEC:   rd_mux = sec_reload;
            A_PRI:   rd_mux = cnt;
            A_STAT:  rd_mux = {6'h00, irq_stat};
            A_MASK:  rd_mux = {6'h00, irq_mask};
            A_PORT:  rd_mux = {7'h00, port_dir ? port_data : wave};
            default: rd_mux = 8'h00;
        endcase
    end

    // Data valid only in the cycle after the read strobe
    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            rdata <= 8'h00;
        end else begin
            rdata <= I_BUS.rd ? rd_mux : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign O_RDATA   = rdata;
    assign O_WAVE    = wave;
    assign O_WAVE_OE = port_dir;
    assign O_IRQ     = irq;

endmodule

/* ptmr_assertions.sv */
// Port checker for the prescaled one-shot waveform timer
module ptmr_chk
    import ptmr_pkg::*;
(
    // Clock and reset
    input wire logic                   I_CLK,
    input wire logic                   I_NRST,
    // Register port
    input wire ptmr_pkg::ptmr_bus_t    I_BUS,
    input wire logic [ptmr_pkg::DW-1:0] O_RDATA,
    // Pins and interrupt
    input wire logic                   I_TRIG,
    input wire logic                   O_WAVE,
    input wire logic                   O_WAVE_OE,
    input wire logic                   O_IRQ
);
    // ------------------------
    // Decode of control writes
    // ------------------------
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_NRST);
    logic run;                                         // Last start request
    wire  wr_ctrl = I_BUS.wr && I_BUS.addr == A_CTRL;  // Control write
    wire  rd_ctrl = I_BUS.rd && I_BUS.addr == A_CTRL;  // Control read
    wire  go   = wr_ctrl && I_BUS.wdata[B_START] && !I_BUS.wdata[B_FSTOP] && !run;
    wire  halt = wr_ctrl && !I_BUS.wdata[B_START] && !I_BUS.wdata[B_FSTOP] && run;
    wire  kill = wr_ctrl && I_BUS.wdata[B_FSTOP];      // Forced stop
    // Tracks the start bit so that go and halt see a real change of state
    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            run <= 1'b0;
        end else if (wr_ctrl) begin
            run <= I_BUS.wdata[B_START] && !I_BUS.wdata[B_FSTOP];
        end
    end
    // ----------
    // Assertions
    // ----------
    a_rdata_idle: assert property (!$past(I_BUS.rd) |-> O_RDATA == 8'h00)
        else $error("read data not zero outside a read answer");
    a_start_delay: assert property (go ##1 rd_ctrl |=> !O_RDATA[B_STATUS])
        else $error("count status rose without delay");
    a_stop_delay: assert property (halt ##1 rd_ctrl |=> O_RDATA[B_STATUS])
        else $error("count status fell without delay");
    a_fstop_now: assert property (kill ##1 rd_ctrl |=> O_RDATA[1:0] == 2'b00)
        else $error("forced stop did not halt at once");
    a_irq_masked: assert property (
        I_BUS.wr && I_BUS.addr == A_MASK && I_BUS.wdata == 8'h00 |=> ##1 !O_IRQ)
        else $error("interrupt high with all sources masked");
    a_port_level: assert property (
        I_BUS.rd && I_BUS.addr == A_PORT && !O_WAVE_OE |=> O_RDATA[0] == $past(O_WAVE))
        else $error("port read differs from wave level");
    a_oe_dir: assert property (
        I_BUS.wr && I_BUS.addr == A_IOC |-> ##2 O_WAVE_OE == $past(I_BUS.wdata[B_DIR], 2))
        else $error("wave drive enable differs from direction bit");
    a_reset_quiet: assert property ($rose(I_NRST) |-> (!O_IRQ && !O_WAVE) [*8])
        else $error("timer active right after reset");
    c_started: cover property (go ##1 rd_ctrl);
    c_killed: cover property (kill ##1 rd_ctrl);
    c_irq: cover property ($rose(O_IRQ));
endmodule

bind ptmr_top ptmr_chk u_ptmr_chk (
    .I_CLK     (I_CLK),
    .I_NRST    (I_NRST),
    .I_BUS     (I_BUS),
    .O_RDATA   (O_RDATA),
    .I_TRIG    (I_TRIG),
    .O_WAVE    (O_WAVE),
    .O_WAVE_OE (O_WAVE_OE),
    .O_IRQ     (O_IRQ)
);

/* tb_top.sv */
// Self-checking bench for the prescaled one-shot waveform timer
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ptmr_pkg::*;
    // -------
    // Signals
    // -------
    logic          clk;       // 200 MHz clock
    logic          nrst;      // Synchronous reset, active low
    ptmr_bus_t     bus_q;     // Register request
    logic [DW-1:0] rdata;     // Read data
    logic          trig;      // Trigger pin
    logic          wave;      // Waveform level
    logic          wave_oe;   // Wave pin drive enable
    logic          irq;       // Interrupt level
    logic [DW-1:0] q;         // Last read value
    logic [DW-1:0] p;         // Earlier read value
    int            fails;     // Mismatches
    int            compares;  // Comparisons
    int            cyc;       // Cycles run, for the hang limit
    typedef struct packed {
        logic          w;  // Write when set
        logic [AW-1:0] a;  // Address
        logic [DW-1:0] d;  // Write data or expected read
    } ptmr_row_t;
    // Reset values, an unmapped place, then loads read back while stopped
    localparam ptmr_row_t ROWS [15] = '{
        '{1'b0, A_PRE, 8'hff}, '{1'b0, A_PRI, 8'hff}, '{1'b0, A_SEC, 8'hff},
        '{1'b0, A_CTRL, 8'h00}, '{1'b0, A_MODE, 8'h00}, '{1'b0, A_STAT, 8'h00},
        '{1'b0, A_MASK, 8'h00}, '{1'b1, 4'hf, 8'h5a}, '{1'b0, 4'hf, 8'h00},
        '{1'b1, A_PRE, 8'h03}, '{1'b0, A_PRE, 8'h03}, '{1'b1, A_PRI, 8'h02},
        '{1'b0, A_PRI, 8'h02}, '{1'b1, A_MASK, 8'h01}, '{1'b0, A_MASK, 8'h01}
    };
    ptmr_top u_ptmr_top (
        .I_CLK     (clk),
        .I_NRST    (nrst),
        .I_BUS     (bus_q),
        .O_RDATA   (rdata),
        .I_TRIG    (trig),
        .O_WAVE    (wave),
        .O_WAVE_OE (wave_oe),
        .O_IRQ     (irq)
    );
    // -----
    // Tasks
    // -----
    task automatic chk(input string n, input logic [DW-1:0] got, input logic [DW-1:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, exp, got);
        end
    endtask
    // One access; the idle cycle after it keeps each strobe to one cycle
    task automatic bus(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk);
        bus_q <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge clk);
        bus_q <= '0;
        #1 q = rdata;
    endtask
    // Write followed at once by a read, to catch a status mid-transition
    task automatic wrrd(input logic [AW-1:0] wa, input logic [DW-1:0] wd, input logic [AW-1:0] ra);
        @(posedge clk);
        bus_q <= '{addr: wa, wdata: wd, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_q <= '{addr: ra, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_q <= '0;
        #1 q = rdata;
    endtask
    // Only this register is read while a start or stop is pending
    task automatic poll(input logic [AW-1:0] a, input int b, input logic v);
        bus(1'b0, a, 8'h00);
        for (int k = 0; k < 30 && q[b] !== v; k++) begin
            bus(1'b0, a, 8'h00);
        end
    endtask
    task automatic do_reset();
        nrst <= 1'b0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
    endtask
    task automatic summarize();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ------------------------
    // Clock, hang limit, tests
    // ------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // The tests need about 200 cycles; far above that means a hang
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            summarize();
        end
    end
    initial begin
        bus_q = '0;
        trig = 1'b0;
        nrst = 1'b0;
        fails = 0;
        compares = 0;
        cyc = 0;
        do_reset();
        foreach (ROWS[i]) begin
            bus(ROWS[i].w, ROWS[i].a, ROWS[i].d);
            if (!ROWS[i].w) chk("row read", q, ROWS[i].d);
        end
        // Timer mode: start, underflow interrupt, mask, stop
        wrrd(A_CTRL, 8'h01, A_CTRL);
        chk("status at start", q & 8'h02, 8'h00);
        poll(A_CTRL, B_STATUS, 1'b1);
        chk("status running", q & 8'h02, 8'h02);
        for (int k = 0; k < 40 && irq !== 1'b1; k++) #5;
        chk("irq raised", {7'h0, irq}, 8'h01);
        bus(1'b0, A_STAT, 8'h00);
        chk("underflow flag", q & 8'h01, 8'h01);
        bus(1'b0, A_STAT, 8'h00);
        chk("flag cleared", q, 8'h00);
        bus(1'b1, A_MASK, 8'h00);
        #75;
        chk("irq masked", {7'h0, irq}, 8'h00);
        bus(1'b0, A_STAT, 8'h00);
        chk("sticky under mask", q & 8'h01, 8'h01);
        wrrd(A_CTRL, 8'h00, A_CTRL);
        chk("status at stop", q & 8'h02, 8'h02);
        poll(A_CTRL, B_STATUS, 1'b0);
        chk("status stopped", q & 8'h02, 8'h00);
        bus(1'b0, A_PRE, 8'h00);
        p = q;
        bus(1'b0, A_PRE, 8'h00);
        chk("halted count", q, p);
        // Waveform mode: port read, forced stop in the primary period
        bus(1'b1, A_MODE, 8'h01);
        wrrd(A_CTRL, 8'h01, A_CTRL);
        poll(A_CTRL, B_STATUS, 1'b1);
        bus(1'b0, A_PORT, 8'h00);
        wrrd(A_CTRL, 8'h04, A_CTRL);
        chk("forced stop", q & 8'h03, 8'h00);
        bus(1'b0, A_PRE, 8'h00);
        chk("prescaler restored", q, PRE_RST);
        bus(1'b0, A_PRI, 8'h00);
        chk("primary restored", q, PRI_RST);
        // One-shot mode: status delays, stop reloads the count
        bus(1'b1, A_MODE, 8'h03);
        bus(1'b1, A_PRE, 8'h03);
        bus(1'b1, A_PRI, 8'h09);
        wrrd(A_CTRL, 8'h01, A_CTRL);
        poll(A_CTRL, B_STATUS, 1'b1);
        wrrd(A_OSC, 8'h01, A_OSC);
        chk("one-shot pending", q & 8'h04, 8'h00);
        bus(1'b0, A_OSC, 8'h00);
        chk("one-shot running", q & 8'h04, 8'h04);
        chk("wave active", {7'h0, wave}, 8'h01);
        wrrd(A_OSC, 8'h02, A_OSC);
        chk("one-shot stop pending", q & 8'h04, 8'h04);
        bus(1'b0, A_OSC, 8'h00);
        chk("one-shot stopped", q & 8'h04, 8'h00);
        bus(1'b0, A_PRI, 8'h00);
        chk("primary reloaded", q, 8'h09);
        bus(1'b0, A_PRE, 8'h00);
        chk("prescaler reloaded", q, 8'h03);
        // Wait one-shot mode started from the trigger pin, then by software
        bus(1'b1, A_MODE, 8'h02);
        bus(1'b1, A_SEC, 8'h01);
        bus(1'b1, A_PRE, 8'h00);
        bus(1'b1, A_PRI, 8'h01);
        bus(1'b1, A_IOC, 8'h02);
        bus(1'b0, A_STAT, 8'h00);
        @(posedge clk);
        trig <= 1'b1;
        repeat (4) @(posedge clk);
        trig <= 1'b0;
        poll(A_STAT, B_OSEND, 1'b1);
        chk("wait one-shot end", q & 8'h02, 8'h02);
        bus(1'b1, A_SEC, 8'h01);
        bus(1'b1, A_PRI, 8'h01);
        bus(1'b1, A_OSC, 8'h01);
        poll(A_STAT, B_OSEND, 1'b1);
        chk("soft wait end", q & 8'h02, 8'h02);
        // Reset in mid-run leaves the timer stopped
        bus(1'b1, A_MODE, 8'h00);
        do_reset();
        bus(1'b0, A_CTRL, 8'h00);
        chk("control after reset", q, 8'h00);
        #50;
        bus(1'b0, A_PRE, 8'h00);
        chk("prescaler held", q, PRE_RST);
        summarize();
    end
endmodule
